// File: design/ucs_consts.svh
// Offsets, field positions, reset values and timing counts of the serial port control block.
// Included by the package and the control module; holds definitions only.
`ifndef UCS_CONSTS_SVH
`define UCS_CONSTS_SVH

// Register byte offsets
`define UCS_OFF_RCV_CTRL 8'h18
`define UCS_OFF_XMT_CTRL 8'h98
`define UCS_OFF_BAUD_DIV 8'h9C
`define UCS_OFF_PORT_DIR 8'h80

// Transmit control field positions
`define UCS_TX_CLK_SRC 7
`define UCS_TX_NINE 6
`define UCS_TX_EN 5
`define UCS_TX_SYNC 4
`define UCS_TX_HIGH_SPD 2
`define UCS_TX_SHIFT_EMPTY 1
`define UCS_TX_NINTH 0

// Receive control field positions
`define UCS_RX_PORT_EN 7
`define UCS_RX_NINE 6
`define UCS_RX_SINGLE 5
`define UCS_RX_CONT 4
`define UCS_RX_ADDR_DET 3
`define UCS_RX_FRAME_ERR 2
`define UCS_RX_OVERRUN 1
`define UCS_RX_NINTH 0

// Port direction bits that carry the serial pins
`define UCS_DIR_CLK_PIN 2
`define UCS_DIR_DATA_PIN 1

// Reset values
`define UCS_RST_XMT_CTRL 8'h02
`define UCS_RST_RCV_CTRL 8'h00
`define UCS_RST_BAUD_DIV 8'h00
`define UCS_RST_PORT_DIR 8'hFF

// Clocks per bit per divisor step, halved for the clock phase
`define UCS_HALF_ASYNC_LOW 6'd32
`define UCS_HALF_ASYNC_HIGH 6'd8
`define UCS_HALF_SYNC 6'd2

// Bus responses
`define UCS_RESP_OKAY 2'b00
`define UCS_RESP_SLVERR 2'b10

`endif

// File: design/ucs_pkg.sv
// Types shared by the serial port control block.
// Assumes the constants header sits next to it on the include path.
`include "ucs_consts.svh"

package ucs_pkg;
  typedef enum logic [1:0] {UCS_ASYNC, UCS_SYNC_MASTER, UCS_SYNC_SLAVE} ucs_mode_e;
  typedef logic [7:0] ucs_byte_t;
  typedef logic [1:0] ucs_resp_t;
endpackage

// File: design/ucs_usart_ctrl.sv
// Control and status logic of a serial port: registers, mode decode, baud timing, pin steering.
// Assumes an AXI4-Lite master on aclk and a shift/framing datapath on the same clock.
`timescale 1ns/100ps
`include "ucs_consts.svh"

// Notes on behaviour
// - Async full duplex, sync master or slave
// - Pins serial only with enable and directions
// - Bit 7 picks sync master or slave
// - Bit 6 picks nine-bit transmit frames
// - Transmit enable; receive enables win in sync
// - Bit 4 selects synchronous mode
// - Bit 2 picks async speed only
// - Shift empty status reads one after reset
// - Bit 0 holds transmitted ninth bit
// - Transmit control bit 3 reads zero
// - Receive bit 7 enables serial port
// - Bit 6 picks nine-bit reception
// - Single receive in master, self-clearing
// - Continuous receive, overrides single receive
// - Address detect gates nine-bit async loads
// - Framing error updates with next byte
// - Overrun cleared by dropping continuous receive
// - Receive bit 0 holds received ninth bit
// - Baud is clock over 64,16,4 times X+1
// - Divisor write restarts baud timer
module ucs_usart_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output ucs_pkg::ucs_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output ucs_pkg::ucs_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_clock_pin_level,
  output logic tx_clock_pin_drive,
  output logic tx_clock_pin_oe,
  input wire logic rx_data_pin_level,
  output logic rx_data_pin_drive,
  output logic rx_data_pin_oe,
  input wire logic dp_serial_out,
  input wire logic dp_shift_empty,
  input wire logic dp_frame_done,
  input wire logic dp_ninth_bit,
  input wire logic dp_frame_bad,
  input wire logic dp_buffer_full,
  output ucs_pkg::ucs_mode_e port_mode,
  output logic port_active,
  output logic transmit_active,
  output logic receive_active,
  output logic tx_nine_bit_select,
  output logic tx_ninth_bit,
  output logic rx_nine_bit_select,
  output logic rx_load_accept,
  output logic shift_tick,
  output logic rx_data_sync
);
  import ucs_pkg::*;

  // Register fields
  logic clock_source_select_ff, tx_nine_ff, transmit_enable_bit_ff, sync_ff;
  logic high_speed_select_ff, shift_reg_empty_ff, tx_ninth_ff;
  logic serial_port_enable_ff, rx_nine_ff, single_receive_enable_ff;
  logic continuous_receive_enable_ff, address_detect_enable_ff;
  logic framing_error_flag_ff, overrun_error_flag_ff, rx_ninth_ff;
  ucs_byte_t baud_divisor_ff, port_b_direction_ff;
  logic nxt_single, nxt_overrun, nxt_framing, nxt_rx_ninth;

  // Bus slave state
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  ucs_resp_t bresp_ff, rresp_ff;

  // Baud timer and pin sampling
  logic [7:0] div_cnt_ff;
  logic [4:0] pre_cnt_ff, pre_reload;
  logic [5:0] half_sel;
  logic phase_ff, half_tick, baud_tick;
  logic ck_meta_ff, ck_sync_ff, ck_prev_ff, dt_meta_ff, dt_sync_ff;
  logic ext_rise;

  // Decoded controls
  logic do_write, wr_lane, wr_rcv, wr_xmt, wr_baud, wr_dir, wr_mapped, rd_mapped;
  logic frame_in, accepted, single_done, is_master, is_slave;
  ucs_byte_t xmt_view, rcv_view, rd_byte;
  localparam ucs_byte_t xmt_reset_val = `UCS_RST_XMT_CTRL;

  // Address match on the low byte of an aligned word
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction

  // Bus handshakes and decode
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_lane = do_write && w_strb_ff[0];
  assign wr_rcv = wr_lane && reg_hit(aw_addr_ff, `UCS_OFF_RCV_CTRL);
  assign wr_xmt = wr_lane && reg_hit(aw_addr_ff, `UCS_OFF_XMT_CTRL);
  assign wr_baud = wr_lane && reg_hit(aw_addr_ff, `UCS_OFF_BAUD_DIV);
  assign wr_dir = wr_lane && reg_hit(aw_addr_ff, `UCS_OFF_PORT_DIR);
  assign wr_mapped = reg_hit(aw_addr_ff, `UCS_OFF_RCV_CTRL)
    || reg_hit(aw_addr_ff, `UCS_OFF_XMT_CTRL) || reg_hit(aw_addr_ff, `UCS_OFF_BAUD_DIV)
    || reg_hit(aw_addr_ff, `UCS_OFF_PORT_DIR);
  assign rd_mapped = reg_hit(s_axi_araddr, `UCS_OFF_RCV_CTRL)
    || reg_hit(s_axi_araddr, `UCS_OFF_XMT_CTRL) || reg_hit(s_axi_araddr, `UCS_OFF_BAUD_DIV)
    || reg_hit(s_axi_araddr, `UCS_OFF_PORT_DIR);

  // Status views; bit 3 of transmit control is unimplemented
  assign xmt_view = {clock_source_select_ff, tx_nine_ff, transmit_enable_bit_ff, sync_ff,
    1'b0, high_speed_select_ff, shift_reg_empty_ff, tx_ninth_ff};
  assign rcv_view = {serial_port_enable_ff, rx_nine_ff, single_receive_enable_ff,
    continuous_receive_enable_ff, address_detect_enable_ff, framing_error_flag_ff,
    overrun_error_flag_ff, rx_ninth_ff};
  assign rd_byte = reg_hit(s_axi_araddr, `UCS_OFF_RCV_CTRL) ? rcv_view :
    reg_hit(s_axi_araddr, `UCS_OFF_XMT_CTRL) ? xmt_view :
    reg_hit(s_axi_araddr, `UCS_OFF_BAUD_DIV) ? baud_divisor_ff :
    reg_hit(s_axi_araddr, `UCS_OFF_PORT_DIR) ? port_b_direction_ff : 8'h00;

  // Write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `UCS_RESP_OKAY;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? `UCS_RESP_OKAY : `UCS_RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // Read channel, data from a flip-flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `UCS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_mapped ? `UCS_RESP_OKAY : `UCS_RESP_SLVERR;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // Mode decode from sync and clock source bits
  assign is_master = sync_ff && clock_source_select_ff;
  assign is_slave = sync_ff && !clock_source_select_ff;
  assign port_mode = !sync_ff ? UCS_ASYNC : (is_master ? UCS_SYNC_MASTER : UCS_SYNC_SLAVE);
  assign port_active = serial_port_enable_ff && port_b_direction_ff[`UCS_DIR_CLK_PIN]
    && port_b_direction_ff[`UCS_DIR_DATA_PIN];
  assign receive_active = port_active && (continuous_receive_enable_ff
    || (is_master && single_receive_enable_ff));
  assign transmit_active = port_active && transmit_enable_bit_ff
    && !(sync_ff && (single_receive_enable_ff || continuous_receive_enable_ff));
  assign tx_nine_bit_select = tx_nine_ff;
  assign tx_ninth_bit = tx_ninth_ff;
  assign rx_nine_bit_select = rx_nine_ff;

  // Received frame handling: address gate, flags, single receive completion
  assign frame_in = dp_frame_done && receive_active;
  assign rx_load_accept = !(!sync_ff && rx_nine_ff && address_detect_enable_ff)
    || dp_ninth_bit;
  assign accepted = frame_in && rx_load_accept && !dp_buffer_full;
  assign single_done = frame_in && is_master && !continuous_receive_enable_ff;
  assign nxt_single = wr_rcv ? w_data_ff[`UCS_RX_SINGLE] :
    (single_done ? 1'b0 : single_receive_enable_ff);
  assign nxt_overrun = (frame_in && dp_buffer_full) ? 1'b1 :
    (continuous_receive_enable_ff ? overrun_error_flag_ff : 1'b0);
  assign nxt_framing = accepted ? dp_frame_bad : framing_error_flag_ff;
  assign nxt_rx_ninth = accepted ? dp_ninth_bit : rx_ninth_ff;

  // Receive control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {serial_port_enable_ff, rx_nine_ff, single_receive_enable_ff,
        continuous_receive_enable_ff, address_detect_enable_ff, framing_error_flag_ff,
        overrun_error_flag_ff, rx_ninth_ff} <= `UCS_RST_RCV_CTRL;
    end
    else
    begin
      if (wr_rcv)
      begin
        serial_port_enable_ff <= w_data_ff[`UCS_RX_PORT_EN];
        rx_nine_ff <= w_data_ff[`UCS_RX_NINE];
        continuous_receive_enable_ff <= w_data_ff[`UCS_RX_CONT];
        address_detect_enable_ff <= w_data_ff[`UCS_RX_ADDR_DET];
      end
      single_receive_enable_ff <= nxt_single;
      overrun_error_flag_ff <= nxt_overrun;
      framing_error_flag_ff <= nxt_framing;
      rx_ninth_ff <= nxt_rx_ninth;
    end
  end

  // Transmit control, divisor and direction registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {clock_source_select_ff, tx_nine_ff, transmit_enable_bit_ff, sync_ff} <= 4'h0;
      high_speed_select_ff <= xmt_reset_val[`UCS_TX_HIGH_SPD];
      shift_reg_empty_ff <= xmt_reset_val[`UCS_TX_SHIFT_EMPTY];
      tx_ninth_ff <= xmt_reset_val[`UCS_TX_NINTH];
      baud_divisor_ff <= `UCS_RST_BAUD_DIV;
      port_b_direction_ff <= `UCS_RST_PORT_DIR;
    end
    else
    begin
      shift_reg_empty_ff <= dp_shift_empty;
      if (wr_xmt)
      begin
        clock_source_select_ff <= w_data_ff[`UCS_TX_CLK_SRC];
        tx_nine_ff <= w_data_ff[`UCS_TX_NINE];
        transmit_enable_bit_ff <= w_data_ff[`UCS_TX_EN];
        sync_ff <= w_data_ff[`UCS_TX_SYNC];
        high_speed_select_ff <= w_data_ff[`UCS_TX_HIGH_SPD];
        tx_ninth_ff <= w_data_ff[`UCS_TX_NINTH];
      end
      if (wr_baud)
        baud_divisor_ff <= w_data_ff[7:0];
      if (wr_dir)
        port_b_direction_ff <= w_data_ff[7:0];
    end
  end

  // Baud timer: divisor steps, then a half-bit prescale, then a phase toggle
  assign half_sel = sync_ff ? `UCS_HALF_SYNC :
    (high_speed_select_ff ? `UCS_HALF_ASYNC_HIGH : `UCS_HALF_ASYNC_LOW);
  assign pre_reload = 5'(half_sel - 6'd1);
  assign half_tick = (div_cnt_ff == 8'h00) && (pre_cnt_ff == 5'd0);
  assign baud_tick = half_tick && phase_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || wr_baud || !serial_port_enable_ff)
    begin
      div_cnt_ff <= 8'h00;
      pre_cnt_ff <= 5'd0;
      phase_ff <= 1'b0;
    end
    else if (div_cnt_ff == 8'h00)
    begin
      div_cnt_ff <= baud_divisor_ff;
      pre_cnt_ff <= (pre_cnt_ff == 5'd0) ? pre_reload : 5'(pre_cnt_ff - 5'd1);
      phase_ff <= half_tick ? !phase_ff : phase_ff;
    end
    else
      div_cnt_ff <= 8'(div_cnt_ff - 8'h01);
  end

  // Two-stage capture of the pins, then edge detect on the clean copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {ck_meta_ff, ck_sync_ff, ck_prev_ff} <= 3'b111;
      {dt_meta_ff, dt_sync_ff} <= 2'b11;
    end
    else
    begin
      ck_meta_ff <= tx_clock_pin_level;
      ck_sync_ff <= ck_meta_ff;
      ck_prev_ff <= ck_sync_ff;
      dt_meta_ff <= rx_data_pin_level;
      dt_sync_ff <= dt_meta_ff;
    end
  end

  assign ext_rise = ck_sync_ff && !ck_prev_ff;
  assign rx_data_sync = dt_sync_ff;
  assign shift_tick = port_active && (is_slave ? ext_rise : baud_tick);

  // Pin steering: async uses clock pin as line out; sync drives data when sending
  assign tx_clock_pin_oe = port_active && (!sync_ff || is_master);
  assign tx_clock_pin_drive = sync_ff ? phase_ff : dp_serial_out;
  assign rx_data_pin_oe = port_active && sync_ff && transmit_active;
  assign rx_data_pin_drive = dp_serial_out;

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_pins_gated;
    !port_active |-> !tx_clock_pin_oe && !rx_data_pin_oe && !shift_tick;
  endproperty
  a_pins_gated: assert property (p_pins_gated) else $error("pin driven while port off");

  property p_slave_no_clock;
    is_slave |-> !tx_clock_pin_oe;
  endproperty
  a_slave_no_clock: assert property (p_slave_no_clock) else $error("slave drives clock");

  property p_rx_over_tx;
    (sync_ff && continuous_receive_enable_ff) |-> !transmit_active && !rx_data_pin_oe;
  endproperty
  a_rx_over_tx: assert property (p_rx_over_tx) else $error("transmit not overridden");

  property p_bit3_zero;
    (s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr, `UCS_OFF_XMT_CTRL))
      |=> !s_axi_rdata[3] && (s_axi_rdata[1] == $past(shift_reg_empty_ff));
  endproperty
  a_bit3_zero: assert property (p_bit3_zero) else $error("transmit status read wrong");

  property p_single_clears;
    (single_done && !wr_rcv) |=> !single_receive_enable_ff;
  endproperty
  a_single_clears: assert property (p_single_clears) else $error("single receive stuck");

  property p_addr_gate;
    (frame_in && !sync_ff && rx_nine_ff && address_detect_enable_ff && !dp_ninth_bit)
      |=> $stable(framing_error_flag_ff) && $stable(rx_ninth_ff);
  endproperty
  a_addr_gate: assert property (p_addr_gate) else $error("address frame not dropped");

  property p_overrun_clear;
    (!continuous_receive_enable_ff && !(frame_in && dp_buffer_full)) |=> !overrun_error_flag_ff;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

  property p_overrun_set;
    (frame_in && dp_buffer_full) |=> overrun_error_flag_ff;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun lost");

  property p_divisor_restart;
    (wr_baud && serial_port_enable_ff) |=> (div_cnt_ff == 8'h00)
      ##1 (div_cnt_ff == $past(baud_divisor_ff));
  endproperty
  a_divisor_restart: assert property (p_divisor_restart) else $error("timer not cleared");

  property p_sync_tick_gap;
    (baud_tick && is_master && baud_divisor_ff == 8'h00 && !do_write) ##1 (!do_write)[*3]
      |=> baud_tick;
  endproperty
  a_sync_tick_gap: assert property (p_sync_tick_gap) else $error("sync bit period wrong");

  c_async_tx: cover property (transmit_active && !sync_ff);
  c_overrun: cover property (frame_in && dp_buffer_full);
  c_single_done: cover property (single_done);
  c_slave_edge: cover property (is_slave && shift_tick);
endmodule

// File: tb/ucs_serial_peer.sv
// Serial peer model: drives the clock pin and the data pin from outside.
// Assumes the bench resolves each pin from the block's enable and these levels.
`timescale 1ns/100ps
module ucs_serial_peer (
  input wire logic run,
  output logic link_clk,
  output logic link_dat
);
  // Clock idles high between frames; data toggles every bit
  initial
  begin
    link_clk = 1'b1;
    link_dat = 1'b1;
  end
  // External clock for slave mode, 48 ns period, only while a frame runs
  always
  begin
    wait (run);
    #24 link_clk = 1'b0;
    link_dat = ~link_dat;
    #24 link_clk = 1'b1;
  end
endmodule

// File: tb/ucs_usart_ctrl_tb.sv
// Bench for the serial port control block: registers, modes, pin gating, baud timing, flags.
// Assumes the design files and the serial peer model are compiled before it.
`timescale 1ns/100ps
`include "ucs_consts.svh"
module ucs_usart_ctrl_tb;
  import ucs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, run = 1'b0;
  logic se = 1'b1, sout = 1'b0, fdone = 1'b0, ninth = 1'b0, fbad = 1'b0, bfull = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, peer_clk, peer_dat;
  logic ck_drv, ck_oe, dt_drv, dt_oe, port_active, transmit_active, receive_active;
  logic tx9s, tx9b, rx9s, rx_load_accept, shift_tick, rx_data_sync;
  logic [31:0] rdata;
  logic [31:0] seed = 32'h41e8_457a;
  ucs_resp_t bresp, rresp, lresp;
  ucs_mode_e port_mode;
  int fails = 0;
  int checks_done = 0;
  // Pins resolve to the block when it drives, else to the peer
  wire logic ck_lvl = ck_oe ? ck_drv : peer_clk;
  wire logic dt_lvl = dt_oe ? dt_drv : peer_dat;
  always #2 aclk = ~aclk;
  ucs_usart_ctrl ucs_usart_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bry), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rry),
    .tx_clock_pin_level(ck_lvl), .tx_clock_pin_drive(ck_drv), .tx_clock_pin_oe(ck_oe),
    .rx_data_pin_level(dt_lvl), .rx_data_pin_drive(dt_drv), .rx_data_pin_oe(dt_oe),
    .dp_serial_out(sout), .dp_shift_empty(se), .dp_frame_done(fdone), .dp_ninth_bit(ninth),
    .dp_frame_bad(fbad), .dp_buffer_full(bfull), .port_mode(port_mode),
    .port_active(port_active), .transmit_active(transmit_active),
    .receive_active(receive_active), .tx_nine_bit_select(tx9s), .tx_ninth_bit(tx9b),
    .rx_nine_bit_select(rx9s), .rx_load_accept(rx_load_accept), .shift_tick(shift_tick),
    .rx_data_sync(rx_data_sync));
  ucs_serial_peer ucs_serial_peer_inst (.run(run), .link_clk(peer_clk), .link_dat(peer_dat));
  // Linear feedback shift register for stimulus
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected transmit control readback: bit 3 zero, bit 1 shift status
  function automatic logic [31:0] exp_xmt(input logic [7:0] w, input logic s);
    return {24'h0, w[7:4], 1'b0, w[2], s, w[0]};
  endfunction
  // Expected clocks per bit
  function automatic int exp_per(input logic [7:0] x, input logic sync, input logic hs);
    return (sync ? 4 : (hs ? 16 : 64)) * (x + 1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Bus write: address and data together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    lresp = bresp;
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (arready) arv <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    d = rdata;
    lresp = rresp;
    rry <= 1'b0;
  endtask
  // One received frame from the datapath
  task automatic frame;
    @(posedge aclk);
    fdone <= 1'b1;
    @(posedge aclk);
    fdone <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic tick_gap(output int n);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (shift_tick !== 1'b1 && n < 20000);
  endtask
  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    logic [31:0] d;
    logic [7:0] codes [3];
    int n, p;
    codes = '{8'h00, 8'h04, 8'h90};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`UCS_OFF_XMT_CTRL, d);
    chk(d, 32'h0000_0002);
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d & 32'h0000_00FE, 32'h0000_0000);
    axr(8'h44, d);
    chk(d, 32'h0000_0000);
    chk(lresp, `UCS_RESP_SLVERR);
    axw(8'h44, 32'h0000_00FF);
    chk(lresp, `UCS_RESP_SLVERR);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      se <= seed[8];
      sout <= seed[9];
      axw(`UCS_OFF_XMT_CTRL, {24'h0, seed[7:0]});
      axr(`UCS_OFF_XMT_CTRL, d);
      chk(d, exp_xmt(seed[7:0], seed[8]));
      chk(tx9s, seed[6]);
      chk(tx9b, seed[0]);
    end
    se <= 1'b1;
    $display("test registers done");
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_0080);
    for (int i = 0; i < 4; i++)
    begin
      axw(`UCS_OFF_PORT_DIR, {24'h0, 5'h1F, i[1:0], 1'b1});
      chk(port_active, i == 3);
      axw(`UCS_OFF_PORT_DIR, 32'h0000_00FF);
      axw(`UCS_OFF_XMT_CTRL, {24'h0, i[1], 2'b00, i[0], 4'h0});
      chk(port_mode, !i[0] ? UCS_ASYNC : (i[1] ? UCS_SYNC_MASTER : UCS_SYNC_SLAVE));
      chk(ck_oe, !i[0] || i[1]);
    end
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_0000);
    chk(port_active, 1'b0);
    chk(ck_oe, 1'b0);
    $display("test modes done");
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_0080);
    foreach (codes[k])
    begin
      seed = lfsr(seed);
      axw(`UCS_OFF_XMT_CTRL, {24'h0, codes[k]});
      axw(`UCS_OFF_BAUD_DIV, 32'h0000_00FF);
      repeat (20) @(posedge aclk);
      axw(`UCS_OFF_BAUD_DIV, {30'h0, seed[1:0]});
      tick_gap(n);
      chk(n <= exp_per(seed[1:0], codes[k][4], codes[k][2]) + 2, 1'b1);
      tick_gap(p);
      chk(p, exp_per(seed[1:0], codes[k][4], codes[k][2]));
    end
    axw(`UCS_OFF_BAUD_DIV, 32'h0000_0000);
    axw(`UCS_OFF_XMT_CTRL, 32'h0000_0010);
    run <= 1'b1;
    n = 0;
    repeat (240)
    begin
      @(posedge aclk);
      if (shift_tick === 1'b1) n++;
    end
    run <= 1'b0;
    chk(n >= 19 && n <= 21, 1'b1);
    repeat (30) @(posedge aclk);
    chk(rx_data_sync, peer_dat);
    $display("test baud done");
    axw(`UCS_OFF_XMT_CTRL, 32'h0000_00B0);
    chk(transmit_active, 1'b1);
    chk(dt_oe, 1'b1);
    chk(dt_drv, sout);
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_0090);
    chk(transmit_active, 1'b0);
    chk(receive_active, 1'b1);
    chk(dt_oe, 1'b0);
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_00A0);
    chk(receive_active, 1'b1);
    frame();
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d[5], 1'b0);
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_00B0);
    frame();
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d[5], 1'b1);
    $display("test sync receive done");
    axw(`UCS_OFF_XMT_CTRL, 32'h0000_0000);
    chk(ck_drv, sout);
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_0090);
    fbad <= 1'b1;
    ninth <= 1'b1;
    frame();
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d, 32'h0000_0095);
    bfull <= 1'b1;
    frame();
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d, 32'h0000_0097);
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_0080);
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d, 32'h0000_0085);
    bfull <= 1'b0;
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_00D8);
    ninth <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(rx_load_accept, 1'b0);
    chk(rx9s, 1'b1);
    fbad <= 1'b0;
    frame();
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d, 32'h0000_00DD);
    ninth <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(rx_load_accept, 1'b1);
    frame();
    axr(`UCS_OFF_RCV_CTRL, d);
    chk(d, 32'h0000_00D9);
    axw(`UCS_OFF_RCV_CTRL, 32'h0000_00D0);
    ninth <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(rx_load_accept, 1'b1);
    $display("test async flags done");
    stop_test();
  end
endmodule
